// ==== logic/frf_formatter.sv ====
// floating-point result formatter feeding the register file write port
// How it works
// - single denormal: IEEE keeps it with trailing zeros, non-IEEE gives zero
// - double denormal: IEEE returns it, non-IEEE gives zero
// - single integer goes to low word; non-IEEE invalid writes 0x8000
// - double integer results are not supported and never written
// - non-IEEE mode follows bit 29 of the status/control word
`timescale 1ns/100ps
module frf_formatter
  import frf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // status and control word
  input wire logic [31:0] float_status_control,
  // execution datapath result
  input wire logic res_valid,
  input wire logic [63:0] res_data,
  input wire frf_type_e res_type,
  input wire logic res_dbl,
  input wire logic res_invalid,
  input wire logic [4:0] res_dest,
  // register file write port
  output logic float_register_we,
  output logic [4:0] float_register_addr,
  output logic [63:0] float_register_data,
  output logic non_ieee_mode_select
);
  frf_res_if res ();
  frf_select u_sel (
    .res(res)
  );

  logic mode_r;
  logic mode_nxt;
  logic we_r;
  logic we_nxt;
  logic [4:0] addr_r;
  logic [4:0] addr_nxt;
  logic [63:0] data_r;
  logic [63:0] data_nxt;
  frf_state_e st_r;
  frf_state_e st_nxt;

  assign res.raw = res_data;
  assign res.rtype = res_type;
  assign res.dbl = res_dbl;
  assign res.invalid = res_invalid;
  // mode from the live word so a result sees the current setting
  assign res.non_ieee = float_status_control[FRF_NON_IEEE_BIT];

  always_comb begin
    mode_nxt = float_status_control[FRF_NON_IEEE_BIT];
    we_nxt = 1'b0;
    addr_nxt = addr_r;
    data_nxt = data_r;
    st_nxt = FRF_IDLE;
    case (st_r)
      FRF_IDLE, FRF_WRITE: begin
        if (res_valid && res.keep) begin
          we_nxt = 1'b1;
          addr_nxt = res_dest;
          data_nxt = res.fmt;
          st_nxt = FRF_WRITE;
        end
      end
      default: begin
        st_nxt = FRF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 5'h00;
      data_r <= FRF_RST_DATA;
      st_r <= FRF_IDLE;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      st_r <= st_nxt;
    end
  end

  assign float_register_we = we_r;
  assign float_register_addr = addr_r;
  assign float_register_data = data_r;
  assign non_ieee_mode_select = mode_r;

  // antecedents: one result of each kind taken at an enabled edge
  sequence s_sp_denorm_flush;
    clk_en && res_valid && res_type == FRF_DENORM && !res_dbl &&
      float_status_control[FRF_NON_IEEE_BIT];
  endsequence

  sequence s_sp_denorm_keep;
    clk_en && res_valid && res_type == FRF_DENORM && !res_dbl &&
      !float_status_control[FRF_NON_IEEE_BIT];
  endsequence

  sequence s_dp_denorm_flush;
    clk_en && res_valid && res_type == FRF_DENORM && res_dbl &&
      float_status_control[FRF_NON_IEEE_BIT];
  endsequence

  sequence s_dp_denorm_keep;
    clk_en && res_valid && res_type == FRF_DENORM && res_dbl &&
      !float_status_control[FRF_NON_IEEE_BIT];
  endsequence

  sequence s_int_bad_flush;
    clk_en && res_valid && res_type == FRF_INT && !res_dbl &&
      res_invalid && float_status_control[FRF_NON_IEEE_BIT];
  endsequence

  sequence s_int_plain;
    clk_en && res_valid && res_type == FRF_INT && !res_dbl &&
      !(res_invalid && float_status_control[FRF_NON_IEEE_BIT]);
  endsequence

  sequence s_int_dbl;
    clk_en && res_valid && res_type == FRF_INT && res_dbl;
  endsequence

  sequence s_pass;
    clk_en && res_valid && (res_type == FRF_NORMAL ||
      res_type == FRF_INF || res_type == FRF_ZERO);
  endsequence

  sequence s_nan;
    clk_en && res_valid && (res_type == FRF_SNAN || res_type == FRF_QNAN);
  endsequence

  // any taken result that must reach the register file
  sequence s_write;
    clk_en && res_valid && !(res_type == FRF_INT && res_dbl);
  endsequence

  // a low enable must leave every output where it was
  sequence s_frozen;
    !clk_en;
  endsequence

  AST_SP_DENORM_FLUSH: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_sp_denorm_flush |=> float_register_we &&
      float_register_data[62:0] == 63'h0)
    else $error("single denormal not flushed");

  AST_SP_DENORM_TRAIL: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_sp_denorm_keep |=> float_register_we &&
      float_register_data[28:0] == 29'h0 &&
      float_register_data[63:29] == $past(res_data[63:29]))
    else $error("single denormal not padded");

  AST_DP_DENORM_FLUSH: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_dp_denorm_flush |=> float_register_we &&
      float_register_data[62:0] == 63'h0)
    else $error("double denormal not flushed");

  AST_DP_DENORM_KEEP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_dp_denorm_keep |=> float_register_we &&
      float_register_data == $past(res_data))
    else $error("double denormal changed");

  AST_INT_INVALID: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_int_bad_flush |=> float_register_we &&
      float_register_data == {48'h0, FRF_INT_INVALID})
    else $error("invalid integer pattern wrong");

  AST_INT_LOW: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_int_plain |=> float_register_we &&
      float_register_data == {32'h0, $past(res_data[31:0])})
    else $error("integer not in low word");

  AST_WR_ADDR: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_write |=> float_register_we && float_register_addr == $past(res_dest))
    else $error("write address wrong");

  AST_NO_DBL_INT: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_int_dbl |=> !float_register_we)
    else $error("double integer written");

  AST_PASS: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_pass |=> float_register_we && float_register_data == $past(res_data))
    else $error("pass-through changed");

  AST_QNAN: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_nan |=> float_register_we && float_register_data[51] &&
      float_register_data[63:52] == $past(res_data[63:52]) &&
      float_register_data[50:0] == $past(res_data[50:0]))
    else $error("nan not delivered quiet");

  AST_MODE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> non_ieee_mode_select ==
      $past(float_status_control[FRF_NON_IEEE_BIT]))
    else $error("mode bit not tracked");

  AST_MODE_HOLD: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_frozen |=> $stable(non_ieee_mode_select))
    else $error("mode bit moved while frozen");

  AST_WRITE_HOLD: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_frozen |=> $stable(float_register_we) &&
      $stable(float_register_addr) && $stable(float_register_data))
    else $error("write port moved while frozen");
endmodule : frf_formatter

// ==== pkg/frf_pkg.sv ====
// shared constants and types for the fp result formatter
package frf_pkg;
  localparam int FRF_W = 64;
  localparam int FRF_NON_IEEE_BIT = 29;
  localparam logic [15:0] FRF_INT_INVALID = 16'h8000;
  localparam logic [63:0] FRF_RST_DATA = 64'h0000000000000000;
  localparam logic [63:0] FRF_DP_QNAN_BIT = 64'h0008000000000000;
  // singles sit in double layout, so their quiet bit is the double one
  localparam logic [63:0] FRF_SP_QNAN_BIT = 64'h0008000000000000;
  localparam logic [63:0] FRF_SP_TRAIL_MASK = 64'hFFFFFFFFE0000000;
  localparam logic [63:0] FRF_SIGN_MASK = 64'h8000000000000000;
  localparam logic [31:0] FRF_STATUS_RST = 32'h00000000;

  typedef enum logic [2:0] {
    FRF_DENORM = 3'b000,
    FRF_NORMAL = 3'b001,
    FRF_INF = 3'b010,
    FRF_ZERO = 3'b011,
    FRF_QNAN = 3'b100,
    FRF_SNAN = 3'b101,
    FRF_INT = 3'b110
  } frf_type_e;

  typedef enum logic [1:0] {
    FRF_IDLE = 2'b00,
    FRF_WRITE = 2'b01
  } frf_state_e;
endpackage : frf_pkg

// ==== pkg/frf_res_if.sv ====
// result bundle between the formatter and its selection stage
`timescale 1ns/100ps
interface frf_res_if;
  import frf_pkg::*;
  logic [63:0] raw;
  frf_type_e rtype;
  logic dbl;
  logic invalid;
  logic non_ieee;
  logic [63:0] fmt;
  logic keep;
  modport sel (input raw, rtype, dbl, invalid, non_ieee, output fmt, keep);
  modport top (output raw, rtype, dbl, invalid, non_ieee, input fmt, keep);
endinterface : frf_res_if

// ==== logic/frf_select.sv ====
// combinational value selection for one result
`timescale 1ns/100ps
module frf_select
  import frf_pkg::*;
(
  frf_res_if.sel res
);
  always_comb begin
    res.fmt = res.raw;
    res.keep = 1'b1;
    case (res.rtype)
      FRF_DENORM: begin
        if (res.non_ieee) begin
          // flush keeps the sign of the value
          res.fmt = res.raw & FRF_SIGN_MASK;
        end else if (!res.dbl) begin
          res.fmt = res.raw & FRF_SP_TRAIL_MASK;
        end else begin
          res.fmt = res.raw;
        end
      end
      FRF_QNAN, FRF_SNAN: begin
        res.fmt = res.raw | (res.dbl ? FRF_DP_QNAN_BIT
                                     : FRF_SP_QNAN_BIT);
      end
      FRF_INT: begin
        if (res.dbl) begin
          // no double integer format: nothing is written
          res.keep = 1'b0;
        end else if (res.non_ieee && res.invalid) begin
          res.fmt = {32'h00000000, 16'h0000, FRF_INT_INVALID};
        end else begin
          res.fmt = {32'h00000000, res.raw[31:0]};
        end
      end
      default: begin
        res.fmt = res.raw;
      end
    endcase
  end
endmodule : frf_select

// ==== testbench/frf_regfile_model.sv ====
// register file model taking the formatter's write port
`timescale 1ns/100ps
module frf_regfile_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [4:0] addr,
  input wire logic [63:0] data,
  // read port for the bench
  input wire logic [4:0] rd_addr,
  output logic [63:0] rd_data
);
  logic [63:0] regs [32];
  assign rd_data = regs[rd_addr];
  // cleared on reset so stale contents never pass for a fresh write
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 64'h0000000000000000;
      end
    end else if (we) begin
      regs[addr] <= data;
    end
  end
endmodule : frf_regfile_model

// ==== testbench/frf_formatter_test.sv ====
// bench comparing the fp result formatter with a reference model
`timescale 1ns/100ps
module frf_formatter_test;
  import frf_pkg::*;
  logic clk_sys, rst_n, clk_en, res_valid, res_dbl, res_invalid;
  logic [31:0] float_status_control, rnd;
  logic [63:0] res_data, exp_data, float_register_data, rd_data;
  frf_type_e res_type;
  logic [4:0] res_dest, exp_addr, float_register_addr, rd_addr;
  logic float_register_we, non_ieee_mode_select, exp_we, exp_mode;
  logic [63:0] shadow [32];
  int written [$];
  int mismatches, samples_checked;
  frf_formatter frf_formatter_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .float_status_control(float_status_control),
    .res_valid(res_valid), .res_data(res_data), .res_type(res_type),
    .res_dbl(res_dbl), .res_invalid(res_invalid), .res_dest(res_dest),
    .float_register_we(float_register_we),
    .float_register_addr(float_register_addr),
    .float_register_data(float_register_data),
    .non_ieee_mode_select(non_ieee_mode_select));
  frf_regfile_model frf_regfile_model_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .we(float_register_we), .addr(float_register_addr),
    .data(float_register_data), .rd_addr(rd_addr), .rd_data(rd_data));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [63:0] fmt_exp(frf_type_e t, logic d,
      logic flush, logic inv, logic [63:0] v);
    case (t)
      FRF_DENORM: return flush ? (v & FRF_SIGN_MASK) :
        (d ? v : (v & FRF_SP_TRAIL_MASK));
      FRF_QNAN, FRF_SNAN: return v | (d ? FRF_DP_QNAN_BIT : FRF_SP_QNAN_BIT);
      FRF_INT: return (flush && inv) ? {48'h000000000000, FRF_INT_INVALID} :
        {32'h00000000, v[31:0]};
      default: return v;
    endcase
  endfunction : fmt_exp
  task cmp_we(input logic want);
    samples_checked++;
    if (float_register_we !== want) begin
      mismatches++;
      $display("mismatch at %0t: write enable %b want %b", $time,
        float_register_we, want);
    end
  endtask : cmp_we
  task cmp_mode(input logic want);
    samples_checked++;
    if (non_ieee_mode_select !== want) begin
      mismatches++;
      $display("mismatch at %0t: mode %b want %b", $time,
        non_ieee_mode_select, want);
    end
  endtask : cmp_mode
  task cmp_write(input logic [4:0] want_addr, input logic [63:0] want_data);
    samples_checked++;
    if ({float_register_addr, float_register_data} !==
        {want_addr, want_data}) begin
      mismatches++;
      $display("mismatch at %0t: write %h:%h want %h:%h", $time,
        float_register_addr, float_register_data, want_addr, want_data);
    end
  endtask : cmp_write
  task cmp_reg(input logic [63:0] want);
    samples_checked++;
    if (rd_data !== want) begin
      mismatches++;
      $display("mismatch at %0t: register %0d %h want %h", $time,
        rd_addr, rd_data, want);
    end
  endtask : cmp_reg
  task test_done;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  // a frozen clock enable freezes the model too, so checks run every cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {exp_we, exp_mode, exp_addr, exp_data} = '0;
      for (int i = 0; i < 32; i++) begin
        shadow[i] = '0;
      end
      written.delete();
    end else if (clk_en) begin
      exp_we = res_valid && !(res_type == FRF_INT && res_dbl);
      if (exp_we) begin
        exp_addr = res_dest;
        exp_data = fmt_exp(res_type, res_dbl,
          float_status_control[FRF_NON_IEEE_BIT], res_invalid, res_data);
        // shadow of the register file, read back at the end
        shadow[res_dest] = exp_data;
        written.push_back(int'(res_dest));
      end
      exp_mode = float_status_control[FRF_NON_IEEE_BIT];
    end
  end
  always @(negedge clk_sys) begin
    cmp_we(exp_we);
    cmp_mode(exp_mode);
    cmp_write(exp_addr, exp_data);
  end
  initial begin
    {mismatches, samples_checked} = '0;
    rnd = 32'h0000001B;
    {rst_n, clk_en, res_valid, res_dbl, res_invalid} = '0;
    float_status_control = '0;
    rd_addr = '0;
    res_data = '0;
    res_type = FRF_DENORM;
    res_dest = '0;
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1;
    // random types, precisions, modes and stalls; one reset in mid-run
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      #1;
      rnd = xs(rnd);
      res_data = {rnd, xs(rnd)};
      rnd = xs(rnd);
      res_type = frf_type_e'((rnd[2:0] == 3'h7) ? 3'h6 : rnd[2:0]);
      res_dbl = rnd[3];
      res_invalid = rnd[4];
      res_valid = rnd[7:5] != 3'h0;
      clk_en = rnd[10:8] != 3'h0;
      res_dest = rnd[15:11];
      float_status_control = xs(rnd);
      if (i == 1500) rst_n = 0;
      if (i == 1504) rst_n = 1;
    end
    // drain: no new results, then read back every written register
    @(posedge clk_sys);
    #1;
    res_valid = 1'h0;
    clk_en = 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    foreach (written[k]) begin
      rd_addr = 5'(written[k]);
      #1;
      cmp_reg(shadow[rd_addr]);
    end
    test_done();
  end
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule : frf_formatter_test
